// ===== hw/adc_power_sleep_format_ctrl.sv
// Power, sleep, idle and output format control of the 12-bit converter, with an APB register file.
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module adc_power_sleep_format_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter int TAD_DIV   = TAD_CYCLES,
    parameter int BUF_WORDS = 16
) (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        reset,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Power manager, same clock.
    input  wire logic        sleepMode,
    input  wire logic        idleMode,
    // Internal RC oscillator, asynchronous.
    input  wire logic        rcClockIn,
    // Analog core, same clock.
    input  wire logic [11:0] conversionData,
    // Port pins, asynchronous.
    input  wire logic [15:0] pinIn,
    // Analog core control and the wake request.
    output logic             analogPowerOn,
    output logic             convClockRun,
    output logic             conversionStart,
    output logic      [3:0]  muxChannel,
    output logic             pinRouteEnable,
    output logic             wakeRequest
);

    conversion_active_state_t state;
    logic [15:0] ctrl;
    logic [7:0]  channel;
    logic [15:0] analogPinConfig;
    logic [15:0] pinDirection;
    logic        rcOff;
    logic        convDone;
    logic [11:0] resultBuffer [BUF_WORDS];
    logic [3:0]  writePtr;
    logic [7:0]  divCount;
    logic [3:0]  tadCount;
    logic [1:0]  rcSync;
    logic        rcLast;
    logic [15:0] pinMeta;
    logic [15:0] pinSync;

    logic        moduleOn;
    logic        rcSelect;
    logic        irqEnable;
    logic        stopInIdle;
    format_t     outputFormat;
    logic        sleepHalt;
    logic        idleHalt;
    logic        powered;
    logic        clockRun;
    logic        abort;
    logic        tick;
    logic        rcEdge;
    logic        divTick;
    logic        setupPhase;
    logic        writeAccess;
    logic        bufHit;
    logic        regHit;
    logic [3:0]  bufIndex;
    logic [15:0] bufWord;
    logic        startRequest;
    logic        doneClear;
    logic [15:0] statusWord;
    logic [15:0] ctrlRead;
    logic [15:0] next_readWord;

    // Control word: bit 15 module on, bit 13 stop in idle, bits 9:8 output format.
    // Bit 7 selects the RC clock, bit 6 enables the interrupt and bit 1 starts a conversion.
    // Bit 1 is a strobe and bit 0 reads back conversion active, so neither is stored.
    // Status word: bit 0 powered, bit 1 powered down during Sleep, bit 2 done, cleared by writing one.
    // Channel word: bits 3:0 pick the mux A input; bits 7:4 hold mux B, which this block leaves unused.
    // Pin configuration marks analog pins with a one; pin direction marks inputs with a one.
    // The port word shows the synchronised pin levels, with zeros on analog pins.
    // The sixteen result words start at the buffer base and read back in the selected format.
    // Unmapped addresses answer with an error, read as zero and ignore writes.
    localparam logic [15:0] CTRL_WRITE_MASK = (16'h0001 << MODULE_ON_BIT) | (16'h0001 << STOP_IDLE_BIT)
                                              | (16'h0003 << FORMAT_LSB) | (16'h0001 << RC_SEL_BIT)
                                              | (16'h0001 << IRQ_EN_BIT);

    assign moduleOn     = ctrl[MODULE_ON_BIT];
    assign rcSelect     = ctrl[RC_SEL_BIT];
    assign irqEnable    = ctrl[IRQ_EN_BIT];
    assign stopInIdle   = ctrl[STOP_IDLE_BIT];
    assign outputFormat = format_t'(ctrl[FORMAT_LSB +: 2]);

    // Only the RC clock survives Sleep; Idle halts only when asked to.
    assign sleepHalt = sleepMode & ~rcSelect;
    assign idleHalt  = idleMode & stopInIdle;
    assign powered   = moduleOn & ~rcOff;
    assign clockRun  = powered & ~sleepHalt & ~idleHalt;
    assign abort     = ~moduleOn | sleepHalt | rcOff;

    assign analogPowerOn = powered;
    assign convClockRun  = clockRun;

    // The RC oscillator is a foreign clock: two flops, then an edge detect on the second.
    always_ff @(posedge clock) begin
        rcSync <= {rcSync[0], rcClockIn};
        rcLast <= rcSync[1];
    end

    assign rcEdge = rcSync[1] & ~rcLast;

    // Instruction-clock divider that makes one conversion tick per TAD.
    always_ff @(posedge clock) begin
        if (reset || !clockRun || rcSelect || divTick) begin
            divCount <= 8'h00;
        end else begin
            divCount <= divCount + 8'h01;
        end
    end

    assign divTick = clockRun && !rcSelect && (divCount == 8'(TAD_DIV - 1));
    assign tick    = clockRun & (rcSelect ? rcEdge : divTick);

    // Pin inputs pass two flops before the port read logic sees them.
    always_ff @(posedge clock) begin
        pinMeta <= pinIn;
        pinSync <= pinMeta;
    end

    // APB decode; the slave never waits.
    assign setupPhase  = psel & ~penable;
    assign writeAccess = psel & penable & pwrite;
    assign bufHit      = (paddr[7:6] == BUF_BASE[7:6]) && (paddr[1:0] == 2'b00);
    assign bufIndex    = paddr[5:2];
    assign pready      = psel & penable;
    assign pslverr     = psel & penable & ~(bufHit | regHit);

    // Register decode; anything else outside the result buffer is refused with an error.
    always_comb begin
        case (paddr)
            CTRL_OFFSET,
            STATUS_OFFSET,
            CHANNEL_OFFSET,
            PINCFG_OFFSET,
            PINDIR_OFFSET,
            PORT_OFFSET: regHit = 1'b1;
            default:     regHit = 1'b0;
        endcase
    end

    // Start is only taken together with the on bit in the same write.
    assign startRequest = writeAccess && (paddr == CTRL_OFFSET) && pwdata[START_BIT]
                          && pwdata[MODULE_ON_BIT];
    assign doneClear    = writeAccess && (paddr == STATUS_OFFSET) && pwdata[DONE_BIT];

    // Software-written registers; Sleep never touches them.
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl            <= CTRL_RESET;
            channel         <= CHANNEL_RESET;
            analogPinConfig <= PINCFG_RESET;
            pinDirection    <= PINDIR_RESET;
        end else if (writeAccess) begin
            case (paddr)
                CTRL_OFFSET: begin
                    ctrl <= pwdata[15:0] & CTRL_WRITE_MASK;
                end
                CHANNEL_OFFSET: begin
                    channel <= pwdata[7:0];
                end
                PINCFG_OFFSET: begin
                    analogPinConfig <= pwdata[15:0];
                end
                PINDIR_OFFSET: begin
                    pinDirection <= pwdata[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Conversion sequencer.
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= ST_IDLE;
        end else if (abort) begin
            // Abort outranks a start, so a start written together with the first on bit is dropped.
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (startRequest) begin
                        // The clock choice written with the start decides whether the delay cycle is taken.
                        state <= pwdata[RC_SEL_BIT] ? ST_DELAY : ST_CONVERT;
                    end
                end
                ST_DELAY: begin
                    state <= ST_CONVERT;
                end
                ST_CONVERT: begin
                    if (tick && tadCount == 4'(CONVERSION_ACTIVE_TADS - 1)) begin
                        state <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // TAD counter of a running conversion.
    always_ff @(posedge clock) begin
        if (reset || state != ST_CONVERT || abort) begin
            tadCount <= 4'h0;
        end else if (tick) begin
            tadCount <= tadCount + 4'h1;
        end
    end

    assign conversionStart = (state == ST_CONVERT) && (tadCount == 4'h0) && tick;

    // A Sleep-time completion powers the converter down unless it may wake the device.
    always_ff @(posedge clock) begin
        if (reset || !sleepMode || !moduleOn) begin
            rcOff <= 1'b0;
        end else if (state == ST_STORE && !irqEnable) begin
            rcOff <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wakeRequest <= 1'b0;
        end else begin
            wakeRequest <= (state == ST_STORE) && sleepMode && irqEnable;
        end
    end

    // Completion flag; a new completion beats a clear in the same cycle.
    always_ff @(posedge clock) begin
        if (reset) begin
            convDone <= 1'b0;
        end else if (state == ST_STORE) begin
            convDone <= 1'b1;
        end else if (doneClear) begin
            convDone <= 1'b0;
        end
    end

    // Write pointer into the result buffer.
    always_ff @(posedge clock) begin
        if (reset) begin
            writePtr <= 4'h0;
        end else if (state == ST_STORE) begin
            writePtr <= writePtr + 4'h1;
        end
    end

    // Result buffer has no reset; an aborted conversion never reaches the store state.
    always_ff @(posedge clock) begin
        if (writeAccess && bufHit) begin
            resultBuffer[bufIndex] <= pwdata[11:0];
        end
        if (state == ST_STORE) begin
            resultBuffer[writePtr] <= conversionData;
        end
    end

    result_formatter formatter (
        .rawWord (resultBuffer[bufIndex]),
        .format  (outputFormat),
        .busWord (bufWord)
    );

    // Analog routing: channel and direction only pick what is converted.
    assign muxChannel     = channel[MUX_A_LSB +: 4];
    assign pinRouteEnable = analogPinConfig[muxChannel] | ~pinDirection[muxChannel];

    assign statusWord = {13'h0000, convDone, rcOff, powered};
    assign ctrlRead   = ctrl | {15'h0000, state != ST_IDLE};

    always_comb begin
        next_readWord = 16'h0000;
        if (bufHit) begin
            next_readWord = bufWord;
        end else begin
            case (paddr)
                CTRL_OFFSET:    next_readWord = ctrlRead;
                STATUS_OFFSET:  next_readWord = statusWord;
                CHANNEL_OFFSET: next_readWord = {8'h00, channel};
                PINCFG_OFFSET:  next_readWord = analogPinConfig;
                PINDIR_OFFSET:  next_readWord = pinDirection;
                PORT_OFFSET:    next_readWord = pinSync & ~analogPinConfig;
                default:        next_readWord = 16'h0000;
            endcase
        end
    end

    // Read data is captured in the setup cycle and stands through the access cycle.
    // A write cycle leaves the last read data standing.
    always_ff @(posedge clock) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            prdata <= {16'h0000, next_readWord};
        end
    end

endmodule // adc_power_sleep_format_ctrl
`default_nettype wire

// ===== hw/adc_ctrl_pkg.sv
// Shared constants and types of the converter control block.
package adc_ctrl_pkg;

    // Timing.
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int TAD_MIN_NS      = 334;
    localparam int TAD_CYCLES      = (TAD_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int CONVERSION_ACTIVE_TADS       = 14;

    // Register offsets (byte addresses).
    localparam logic [7:0] CTRL_OFFSET    = 8'h00;
    localparam logic [7:0] STATUS_OFFSET  = 8'h04;
    localparam logic [7:0] CHANNEL_OFFSET = 8'h08;
    localparam logic [7:0] PINCFG_OFFSET  = 8'h0C;
    localparam logic [7:0] PINDIR_OFFSET  = 8'h10;
    localparam logic [7:0] PORT_OFFSET    = 8'h14;
    localparam logic [7:0] BUF_BASE       = 8'h40;

    // Control register fields.
    localparam int MODULE_ON_BIT  = 15;
    localparam int STOP_IDLE_BIT  = 13;
    localparam int FORMAT_LSB     = 8;
    localparam int RC_SEL_BIT     = 7;
    localparam int IRQ_EN_BIT     = 6;
    localparam int START_BIT      = 1;
    localparam int ACTIVE_BIT     = 0;

    // Status register fields.
    localparam int POWERED_BIT    = 0;
    localparam int RC_OFF_BIT     = 1;
    localparam int DONE_BIT       = 2;

    // Channel register fields.
    localparam int MUX_A_LSB      = 0;
    localparam int MUX_B_LSB      = 4;

    // Reset values.
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    localparam logic [7:0]  CHANNEL_RESET = 8'h00;
    localparam logic [15:0] PINCFG_RESET  = 16'h0000;
    localparam logic [15:0] PINDIR_RESET  = 16'hFFFF;

    typedef enum logic [1:0] {
        FMT_INT   = 2'b00,
        FMT_SINT  = 2'b01,
        FMT_FRAC  = 2'b10,
        FMT_SFRAC = 2'b11
    } format_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_DELAY   = 2'b01,
        ST_CONVERT = 2'b11,
        ST_STORE   = 2'b10
    } conversion_active_state_t;

endpackage

// ===== hw/result_formatter.sv
// Turns a 12-bit result word into a 16-bit bus word in the chosen format.
`timescale 1ns/10ps
`default_nettype none
module result_formatter
    import adc_ctrl_pkg::*;
(
    // Raw word and format.
    input  wire logic [11:0] rawWord,
    input  wire format_t     format,
    // Bus word.
    output logic      [15:0] busWord
);

    always_comb begin
        case (format)
            FMT_INT:   busWord = {4'h0, rawWord};
            FMT_SINT:  busWord = {{4{rawWord[11]}}, rawWord};
            FMT_FRAC:  busWord = {rawWord, 4'h0};
            FMT_SFRAC: busWord = {rawWord, 4'h0};
            default:   busWord = {4'h0, rawWord};
        endcase
    end

endmodule // result_formatter
`default_nettype wire

// ===== testbench/adc_ctrl_props.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_props
    import adc_ctrl_pkg::*;
(
    // Clock, reset and APB.
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    // Power manager and analog core control.
    input  wire logic        sleepMode,
    input  wire logic        idleMode,
    input  wire logic        analogPowerOn,
    input  wire logic        convClockRun,
    input  wire logic        conversionStart,
    input  wire logic        pinRouteEnable,
    input  wire logic        wakeRequest
);
    logic [15:0] ctrlReg;
    logic [15:0] cfgReg;
    logic [15:0] dirReg;
    logic [3:0]  chanReg;
    // Shadow copies of the registers that gate power and pin routing.
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrlReg <= 16'h0000;
            cfgReg  <= 16'h0000;
            dirReg  <= 16'hFFFF;
            chanReg <= 4'h0;
        end else if (psel && penable && pwrite) begin
            case (paddr)
                CTRL_OFFSET:    ctrlReg <= pwdata[15:0];
                PINCFG_OFFSET:  cfgReg  <= pwdata[15:0];
                PINDIR_OFFSET:  dirReg  <= pwdata[15:0];
                CHANNEL_OFFSET: chanReg <= pwdata[3:0];
                default:        ;
            endcase
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_off_unpowered: assert property (!ctrlReg[MODULE_ON_BIT] |-> !analogPowerOn && !convClockRun)
        else $error("converter powered while module is off");
    a_on_powered: assert property (ctrlReg[MODULE_ON_BIT] && !sleepMode && !$past(sleepMode) |-> analogPowerOn)
        else $error("converter unpowered while module is on");
    a_start_powered: assert property (conversionStart |-> ctrlReg[MODULE_ON_BIT] && analogPowerOn && convClockRun)
        else $error("conversion started without power");
    a_sleep_clock_low: assert property (sleepMode && !ctrlReg[RC_SEL_BIT] |-> !convClockRun)
        else $error("converter clock runs in sleep");
    a_idle_halt: assert property (idleMode && ctrlReg[STOP_IDLE_BIT] |-> !convClockRun)
        else $error("converter clock runs in halted idle");
    a_idle_run: assert property (idleMode && !ctrlReg[STOP_IDLE_BIT] && analogPowerOn && !sleepMode |-> convClockRun)
        else $error("converter clock stopped in idle");
    a_wake_cause: assert property (wakeRequest |-> $past(sleepMode) && ctrlReg[IRQ_EN_BIT] ##1 !wakeRequest)
        else $error("wake request without cause or too long");
    a_reset_off: assert property ($fell(reset) |-> !analogPowerOn && !convClockRun && !wakeRequest)
        else $error("converter active after reset");
    a_read_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_port_analog_zero: assert property (psel && penable && !pwrite && paddr == PORT_OFFSET |-> (prdata[15:0] & cfgReg) == 16'h0000)
        else $error("analog pin reads as one");
    a_pin_route: assert property (pinRouteEnable == (cfgReg[chanReg] || !dirReg[chanReg]))
        else $error("pin routing wrong");
    c_wake: cover property (wakeRequest);
    c_rc_start: cover property (conversionStart && ctrlReg[RC_SEL_BIT]);
    c_sleep_run: cover property (sleepMode && convClockRun);
    c_refused: cover property (pslverr);
endmodule // adc_ctrl_props
bind adc_power_sleep_format_ctrl adc_ctrl_props adc_ctrl_props_i (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .sleepMode(sleepMode), .idleMode(idleMode),
    .analogPowerOn(analogPowerOn), .convClockRun(convClockRun), .conversionStart(conversionStart),
    .pinRouteEnable(pinRouteEnable), .wakeRequest(wakeRequest));
`default_nettype wire

// ===== testbench/analog_side_model.sv
// Model of the analog core result, the free-running RC oscillator and the port pins.
`timescale 1ns/10ps
`default_nettype none
module analog_side_model (
    // Levels chosen by the bench.
    input  wire logic [11:0] sampleValue,
    input  wire logic [15:0] pinLevel,
    // Toward the block.
    output logic             rcClockIn,
    output logic      [11:0] conversionData,
    output logic      [15:0] pinIn
);
    // The RC oscillator runs free, out of phase with the system clock.
    initial begin
        rcClockIn = 1'b0;
        forever #23 rcClockIn = ~rcClockIn;
    end
    assign conversionData = sampleValue;
    assign pinIn          = pinLevel;
endmodule // analog_side_model
`default_nettype wire

// ===== testbench/tb_adc_power_sleep_format_ctrl.sv
// Self-checking bench of the converter control block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; $display("BAD %s expected %h seen %h", nm, exp, got); end end
module tb_adc_power_sleep_format_ctrl
    import adc_ctrl_pkg::*;
;
    localparam logic [31:0] ON = 32'h1 << MODULE_ON_BIT;
    localparam logic [31:0] GO = 32'h1 << START_BIT;
    localparam logic [31:0] RC = 32'h1 << RC_SEL_BIT;
    localparam logic [31:0] IE = 32'h1 << IRQ_EN_BIT;
    localparam logic [31:0] SI = 32'h1 << STOP_IDLE_BIT;
    logic clock, reset, psel, penable, pwrite, pready, pslverr, sleepMode, idleMode, rcClockIn;
    logic analogPowerOn, convClockRun, conversionStart, pinRouteEnable, wakeRequest, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [11:0] conversionData, sampleValue;
    logic [15:0] pinIn, pinLevel;
    logic [3:0]  muxChannel;
    int          mismatches = 0;
    int          n_compared = 0;
    adc_power_sleep_format_ctrl #(.TAD_DIV(2)) adc_power_sleep_format_ctrl_i (
        .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleepMode(sleepMode),
        .idleMode(idleMode), .rcClockIn(rcClockIn), .conversionData(conversionData), .pinIn(pinIn),
        .analogPowerOn(analogPowerOn), .convClockRun(convClockRun), .conversionStart(conversionStart),
        .muxChannel(muxChannel), .pinRouteEnable(pinRouteEnable), .wakeRequest(wakeRequest));
    analog_side_model analog_side_model_i (.sampleValue(sampleValue), .pinLevel(pinLevel),
        .rcClockIn(rcClockIn), .conversionData(conversionData), .pinIn(pinIn));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitDone();
        int n;
        n = 0;
        do begin
            apb(1'b0, STATUS_OFFSET, 32'h0);
            n++;
        end while (rdata[DONE_BIT] !== 1'b1 && n < 200);
    endtask
    function automatic logic [15:0] fmtWord(input logic [1:0] f, input logic [11:0] d);
        case (f)
            2'b00:   return {4'h0, d};
            2'b01:   return {{4{d[11]}}, d};
            default: return {d, 4'h0};
        endcase
    endfunction
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #(20000 * 8);
        mismatches++;
        finish_test();
    end
    initial begin
        {reset, psel, penable, pwrite, sleepMode, idleMode} = 6'b100000;
        paddr = 8'h00;
        pwdata = 32'h0;
        sampleValue = 12'hA5C;
        pinLevel = 16'hFFFF;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        apb(1'b0, CTRL_OFFSET, 32'h0);   `CHK("ctrl reset", CTRL_RESET, rdata[15:0])
        apb(1'b0, PINDIR_OFFSET, 32'h0); `CHK("pindir reset", PINDIR_RESET, rdata[15:0])
        apb(1'b0, 8'h18, 32'h0);         `CHK("unmapped error", 1'b1, rerr)
        $display("test reset_values done");
        apb(1'b1, BUF_BASE, 32'h0000_09A5);
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, CTRL_OFFSET, 32'(f) << FORMAT_LSB);
            apb(1'b0, BUF_BASE, 32'h0);
            `CHK("format word", {16'h0000, fmtWord(2'(f), 12'h9A5)}, rdata)
        end
        $display("test formats done");
        apb(1'b1, CTRL_OFFSET, ON);
        repeat (8) @(posedge clock);
        apb(1'b1, CTRL_OFFSET, ON | GO);
        waitDone();                      `CHK("done", 1'b1, rdata[DONE_BIT])
        apb(1'b0, CTRL_OFFSET, 32'h0);   `CHK("active cleared", 1'b0, rdata[ACTIVE_BIT])
        apb(1'b0, BUF_BASE, 32'h0);      `CHK("result", {4'h0, sampleValue}, rdata[15:0])
        $display("test conversion done");
        apb(1'b1, STATUS_OFFSET, 32'h1 << DONE_BIT);
        apb(1'b1, BUF_BASE + 8'h04, 32'h0000_0123);
        apb(1'b1, CTRL_OFFSET, ON | GO);
        apb(1'b1, CTRL_OFFSET, 32'h0);
        repeat (60) @(posedge clock);
        apb(1'b0, STATUS_OFFSET, 32'h0);       `CHK("no done after off", 1'b0, rdata[DONE_BIT])
        apb(1'b0, BUF_BASE + 8'h04, 32'h0);    `CHK("buffer kept", 16'h0123, rdata[15:0])
        apb(1'b1, CTRL_OFFSET, ON);
        repeat (8) @(posedge clock);
        apb(1'b1, CTRL_OFFSET, ON | GO);
        sleepMode <= 1'b1;
        repeat (60) @(posedge clock);
        sleepMode <= 1'b0;
        repeat (60) @(posedge clock);
        apb(1'b0, STATUS_OFFSET, 32'h0);       `CHK("no done after sleep", 1'b0, rdata[DONE_BIT])
        apb(1'b0, CTRL_OFFSET, 32'h0);         `CHK("ctrl after sleep", ON[15:0], rdata[15:0])
        $display("test aborts done");
        sampleValue <= 12'h3E1;
        apb(1'b1, CTRL_OFFSET, ON | RC | IE | GO);
        sleepMode <= 1'b1;
        for (int n = 0; n < 2000 && wakeRequest !== 1'b1; n++) @(negedge clock);
        `CHK("wake request", 1'b1, wakeRequest)
        @(posedge clock);
        sleepMode <= 1'b0;
        apb(1'b0, BUF_BASE + 8'h04, 32'h0);    `CHK("rc result", 16'h03E1, rdata[15:0])
        apb(1'b1, STATUS_OFFSET, 32'h1 << DONE_BIT);
        apb(1'b1, CTRL_OFFSET, ON | RC | GO);
        sleepMode <= 1'b1;
        for (int n = 0; n < 2000 && analogPowerOn !== 1'b0; n++) @(negedge clock);
        `CHK("rc power off", 1'b0, analogPowerOn)
        apb(1'b0, STATUS_OFFSET, 32'h0);       `CHK("rc off status", 1'b1, rdata[RC_OFF_BIT])
        apb(1'b0, CTRL_OFFSET, 32'h0);         `CHK("module on kept", 1'b1, rdata[MODULE_ON_BIT])
        sleepMode <= 1'b0;
        $display("test sleep done");
        apb(1'b1, CTRL_OFFSET, ON | SI);
        idleMode <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK("idle halted", 1'b0, convClockRun)
        apb(1'b1, CTRL_OFFSET, ON);
        repeat (2) @(posedge clock);
        `CHK("idle running", 1'b1, convClockRun)
        idleMode <= 1'b0;
        $display("test idle done");
        apb(1'b1, PINCFG_OFFSET, 32'h0000_00F0);
        apb(1'b0, PORT_OFFSET, 32'h0);         `CHK("port read", 16'hFF0F, rdata[15:0])
        apb(1'b1, CHANNEL_OFFSET, 32'h0000_0004);
        @(posedge clock);
        `CHK("analog route", 1'b1, pinRouteEnable)
        apb(1'b1, CHANNEL_OFFSET, 32'h0000_0008);
        @(posedge clock);
        `CHK("digital input", 1'b0, pinRouteEnable)
        `CHK("mux channel", 4'h8, muxChannel)
        apb(1'b1, PINDIR_OFFSET, 32'h0000_FEFF);
        @(posedge clock);
        `CHK("driven output", 1'b1, pinRouteEnable)
        $display("test pins done");
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        apb(1'b0, BUF_BASE + 8'h04, 32'h0);    `CHK("buffer after reset", 16'h03E1, rdata[15:0])
        apb(1'b0, CTRL_OFFSET, 32'h0);         `CHK("ctrl after reset", CTRL_RESET, rdata[15:0])
        $display("test reset done");
        finish_test();
    end
endmodule // tb_adc_power_sleep_format_ctrl
`default_nettype wire
